// [rtl/ptws_defines.vh]
// Purpose: constants for the period timer with scalers
// Assumes: byte-wide register port, one word per address
// Notes:   offsets are local choices
`ifndef PTWS_DEFINES_VH
`define PTWS_DEFINES_VH

`define PTWS_ADDR_W        2
`define PTWS_OFF_COUNT     2'h0
`define PTWS_OFF_PERIOD    2'h1
`define PTWS_OFF_CONTROL   2'h2
`define PTWS_OFF_FLAGS     2'h3

`define PTWS_COUNT_RST     8'h00
`define PTWS_PERIOD_RST    8'hFF
`define PTWS_CONTROL_RST   7'h00
`define PTWS_FLAG_RST      1'h0
`define PTWS_RDATA_IDLE    8'h00

`define PTWS_PRE_LSB       0
`define PTWS_PRE_MSB       1
`define PTWS_RUN_BIT       2
`define PTWS_POST_LSB      3
`define PTWS_POST_MSB      6
`define PTWS_FLAG_BIT      1

`define PTWS_PRE_DIV1      2'h0
`define PTWS_PRE_DIV4      2'h1
`define PTWS_PRE_LAST1     4'h0
`define PTWS_PRE_LAST4     4'h3
`define PTWS_PRE_LAST16    4'hF

`endif

// [rtl/ptws_divider.v]
// Purpose: modulo counter producing a tick every (last+1) enables
// Assumes: clear has priority over counting
// Notes:   used for both prescaler and postscaler
`timescale 1ns/10ps

module ptws_divider (
    // clock and reset
    input  wire       clock,
    input  wire       rst_n,
    // control
    input  wire       clear,
    input  wire       enable,
    input  wire [3:0] last,
    // result
    output wire       tick
);

    reg [3:0] cnt_q;
    reg [3:0] cnt_d;

    assign tick = enable && (cnt_q >= last);

    always @* begin
        cnt_d = cnt_q;
        if (clear) begin
            cnt_d = 4'h0;
        end else if (tick) begin
            cnt_d = 4'h0;
        end else if (enable) begin
            cnt_d = cnt_q + 4'h1;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

// [rtl/ptws_timer.v]
// Purpose: 8-bit period timer with prescaler and postscaler
// Assumes: clock is the quarter-oscillator instruction clock
// Notes:   flag register holds only the period event flag
//
// Contract
// - count rises from zero; on period match next increment loads zero
// - period register is read/write and resets to all ones
// - control bits 1:0 divide input: 00 by 1, 01 by 4, 1x by 16
// - control bits 6:3 divide match events by code plus one
// - postscaler terminal count sets flag bit 1 of flag register
// - scalers clear on count write, control write, or reset
// - control write leaves count unchanged
// - count register read/write, reset to zero
// - control bit 2 runs timer; clear stops counting
// - control bit 7 reads zero
// - pre-postscaler match output goes to serial port
// - timer serves as PWM period time base
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "ptws_defines.vh"

module ptws_timer (
    // clock and reset
    input  wire       clock,
    input  wire       rst_n,
    // register port
    input  wire [1:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_write,
    input  wire       reg_read,
    output reg  [7:0] reg_rdata,
    // time base outputs
    output wire       period_match,
    output wire [7:0] pwm_count,
    output wire [7:0] pwm_period,
    output wire       pwm_period_end,
    output wire       period_event_flag
);

    ////////////////////////////////////////////////////////////////////////
    // register state
    reg  [7:0] timer_count_q;
    reg  [7:0] timer_count_d;
    reg  [7:0] period_limit_q;
    reg  [7:0] period_limit_d;
    reg  [6:0] timer_control_q;
    reg  [6:0] timer_control_d;
    reg        flag_q;
    reg        flag_d;
    reg  [7:0] rdata_d;

    // decode
    reg        wr_count;
    reg        wr_period;
    reg        wr_control;
    reg        wr_flags;
    reg  [3:0] pre_last;

    // control fields
    wire       timer_run;
    wire [1:0] pre_divide_select;
    wire [3:0] post_divide_select;

    // time base
    wire       scaler_clear;
    wire       pre_tick;
    wire       post_tick;
    wire       at_limit;
    wire       step;

    ////////////////////////////////////////////////////////////////////////
    // write decode: one strobe per register, none while idle
    always @* begin
        wr_count   = 1'b0;
        wr_period  = 1'b0;
        wr_control = 1'b0;
        wr_flags   = 1'b0;
        if (reg_write) begin
            case (reg_addr)
                `PTWS_OFF_COUNT:   wr_count   = 1'b1;
                `PTWS_OFF_PERIOD:  wr_period  = 1'b1;
                `PTWS_OFF_CONTROL: wr_control = 1'b1;
                `PTWS_OFF_FLAGS:   wr_flags   = 1'b1;
                default:           wr_flags   = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control fields
    assign timer_run          = timer_control_q[`PTWS_RUN_BIT];
    assign pre_divide_select  = timer_control_q[`PTWS_PRE_MSB:`PTWS_PRE_LSB];
    assign post_divide_select = timer_control_q[`PTWS_POST_MSB:`PTWS_POST_LSB];

    // both scalers restart so a new setting starts from a clean phase
    assign scaler_clear = wr_count || wr_control;
    assign at_limit     = (timer_count_q == period_limit_q);
    assign step         = timer_run && pre_tick;

    ////////////////////////////////////////////////////////////////////////
    // prescaler
    always @* begin
        if (pre_divide_select[1]) begin
            pre_last = `PTWS_PRE_LAST16;
        end else if (pre_divide_select == `PTWS_PRE_DIV4) begin
            pre_last = `PTWS_PRE_LAST4;
        end else begin
            pre_last = `PTWS_PRE_LAST1;
        end
    end

    ptws_divider u_pre (
        .clock  (clock),
        .rst_n  (rst_n),
        .clear  (scaler_clear),
        .enable (timer_run),
        .last   (pre_last),
        .tick   (pre_tick)
    );

    // match pulse: one cycle, on the increment that wraps to zero
    assign period_match   = step && at_limit;
    assign pwm_period_end = period_match;
    assign pwm_count      = timer_count_q;
    assign pwm_period     = period_limit_q;

    ptws_divider u_post (
        .clock  (clock),
        .rst_n  (rst_n),
        .clear  (scaler_clear),
        .enable (period_match),
        .last   (post_divide_select),
        .tick   (post_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // count; a software write wins over a same-cycle increment
    always @* begin
        timer_count_d = timer_count_q;
        if (wr_count) begin
            timer_count_d = reg_wdata;
        end else if (step) begin
            if (at_limit) begin
                timer_count_d = 8'h00;
            end else begin
                timer_count_d = timer_count_q + 8'h01;
            end
        end
    end

    // flag: a hardware set wins over a software clear
    always @* begin
        flag_d = flag_q;
        if (wr_flags) begin
            flag_d = reg_wdata[`PTWS_FLAG_BIT];
        end
        if (post_tick) begin
            flag_d = 1'b1;
        end
    end

    // period next value; a period write leaves both scalers running
    always @* begin
        period_limit_d = period_limit_q;
        if (wr_period) begin
            period_limit_d = reg_wdata;
        end
    end

    // bit 7 has no storage, so it can never read back as one
    always @* begin
        timer_control_d = timer_control_q;
        if (wr_control) begin
            timer_control_d = reg_wdata[6:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // storage
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timer_count_q <= `PTWS_COUNT_RST;
        end else begin
            timer_count_q <= timer_count_d;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            period_limit_q <= `PTWS_PERIOD_RST;
        end else begin
            period_limit_q <= period_limit_d;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timer_control_q <= `PTWS_CONTROL_RST;
        end else begin
            timer_control_q <= timer_control_d;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= `PTWS_FLAG_RST;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign period_event_flag = flag_q;

    ////////////////////////////////////////////////////////////////////////
    // read data only in the cycle after the strobe, zero otherwise
    always @* begin
        rdata_d = `PTWS_RDATA_IDLE;
        if (reg_read) begin
            case (reg_addr)
                `PTWS_OFF_COUNT:   rdata_d = timer_count_q;
                `PTWS_OFF_PERIOD:  rdata_d = period_limit_q;
                `PTWS_OFF_CONTROL: rdata_d = {1'b0, timer_control_q};
                `PTWS_OFF_FLAGS:   rdata_d = {6'h00, flag_q, 1'b0};
                default:           rdata_d = `PTWS_RDATA_IDLE;
            endcase
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `PTWS_RDATA_IDLE;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

endmodule

// [verif/ptws_timer_assertions.sv]
// Purpose: port assertions for ptws_timer
// Assumes: one clock domain, async active-low reset
// Notes:   bound onto every ptws_timer
`timescale 1ns/10ps
module ptws_checker (
    // clock and reset
    input wire       clock,
    input wire       rst_n,
    // register port
    input wire [1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_write,
    input wire       reg_read,
    input wire [7:0] reg_rdata,
    // time base outputs
    input wire       period_match,
    input wire [7:0] pwm_count,
    input wire [7:0] pwm_period,
    input wire       pwm_period_end,
    input wire       period_event_flag
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // a count write outranks the wrap
    wire count_wr = reg_write && reg_addr == 2'h0;
    sequence s_free_match;
        period_match && !count_wr;
    endsequence
    chk_match_equal: assert property (period_match |-> pwm_count == pwm_period)
        else $error("match off period");
    chk_match_wrap: assert property (s_free_match |=> pwm_count == 8'h00)
        else $error("count did not wrap");
    chk_pwm_base: assert property (pwm_period_end == period_match)
        else $error("time base outputs differ");
    chk_period_write: assert property
        (reg_write && reg_addr == 2'h1 |=> pwm_period == $past(reg_wdata))
        else $error("period not written");
    chk_count_write: assert property
        (count_wr |=> pwm_count == $past(reg_wdata))
        else $error("count not written");
    chk_ctrl_keeps: assert property
        (reg_write && reg_addr == 2'h2 && !period_match
         |=> pwm_count == $past(pwm_count) || pwm_count == $past(pwm_count) + 8'h01)
        else $error("control write moved count");
    chk_ctrl_top: assert property
        ($past(reg_read && reg_addr == 2'h2) |-> reg_rdata[7] == 1'b0)
        else $error("control bit 7 set");
    chk_flag_held: assert property
        (period_event_flag && !(reg_write && reg_addr == 2'h3) |=> period_event_flag)
        else $error("flag dropped");
endmodule
bind ptws_timer ptws_checker u_chk (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .period_match(period_match), .pwm_count(pwm_count), .pwm_period(pwm_period),
    .pwm_period_end(pwm_period_end), .period_event_flag(period_event_flag));

// [verif/test_period_timer_with_scalers.sv]
// Purpose: directed test of ptws_timer
// Assumes: map 0 count, 1 period, 2 control, 3 flags
// Notes:   every wait is bounded
`timescale 1ns/10ps
module test_period_timer_with_scalers;
    reg        clock = 1'b0;
    reg        rst_n = 1'b0;
    reg  [1:0] reg_addr = 2'h0;
    reg  [7:0] reg_wdata = 8'h00;
    reg        reg_write = 1'b0;
    reg        reg_read = 1'b0;
    wire [7:0] reg_rdata;
    wire       period_match;
    wire [7:0] pwm_count;
    wire [7:0] pwm_period;
    wire       flag;
    wire       period_end;
    integer    mismatches = 0;
    integer    total_checks = 0;
    integer    n;
    always #12.5 clock = ~clock;
    ptws_timer dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .period_match(period_match), .pwm_count(pwm_count), .pwm_period(pwm_period),
        .pwm_period_end(period_end), .period_event_flag(flag));
    ////////////////////////////////////////////////////////////////////////////
    task check(input string what, input [7:0] seen, input [7:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // strobe then an idle cycle, so no signal is assigned twice in one step
    task wr(input [1:0] a, input [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask
    task rd(input [1:0] a, input [7:0] exp);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        check("rdata", reg_rdata, exp);
        @(posedge clock);
    endtask
    // n counts edges since the write edge until the watched value appears
    task wait_for(input use_flag, input [7:0] v);
        #1;
        n = 1;
        while ((use_flag ? {7'h00, flag} : pwm_count) !== v) begin
            if (n == 40) begin
                mismatches = mismatches + 1;
                end_of_test;
            end
            @(posedge clock);
            #1;
            n = n + 1;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task t_regs;
        rd(2'h0, 8'h00);
        rd(2'h1, 8'hFF);
        rd(2'h2, 8'h00);
        wr(2'h1, 8'hA5);
        rd(2'h1, 8'hA5);
        wr(2'h0, 8'h3C);
        wr(2'h2, 8'h80);
        rd(2'h2, 8'h00);
        rd(2'h0, 8'h3C);
        $display("registers done");
    endtask
    task t_prescale(input [1:0] code, input [7:0] d);
        wr(2'h1, 8'hFF);
        wr(2'h2, {5'h00, 1'b1, code});
        wr(2'h0, 8'h10);
        wait_for(1'b0, 8'h11);
        check("prescale edges", n[7:0], d);
        $display("prescale done");
    endtask
    task t_wrap;
        // prescale 1, so the match cycle is the one in which the count shows 2
        wr(2'h2, 8'h04);
        wr(2'h1, 8'h02);
        wr(2'h0, 8'h00);
        wait_for(1'b0, 8'h02);
        check("wrap edges", n[7:0], 8'h02);
        check("match", {7'h00, period_match}, 8'h01);
        check("period end", {7'h00, period_end}, 8'h01);
        check("period out", pwm_period, 8'h02);
        @(posedge clock);
        #1;
        check("count", pwm_count, 8'h00);
        $display("wrap done");
    endtask
    task t_post(input [3:0] code);
        wr(2'h2, 8'h00);
        wr(2'h3, 8'h00);
        wr(2'h1, 8'h00);
        wr(2'h0, 8'h00);
        wr(2'h2, {1'b0, code, 3'h4});
        wait_for(1'b1, 8'h01);
        check("post edges", n[7:0], {4'h0, code} + 8'h01);
        $display("postscale done");
    endtask
    task t_flag;
        wr(2'h2, 8'h00);
        wr(2'h0, 8'h55);
        repeat (5) @(posedge clock);
        rd(2'h0, 8'h55);
        rd(2'h3, 8'h02);
        wr(2'h3, 8'h00);
        rd(2'h3, 8'h00);
        $display("flag done");
    endtask
    // second reset in mid-run, with every register away from its reset value
    task t_reset;
        wr(2'h1, 8'h33);
        wr(2'h0, 8'h44);
        wr(2'h3, 8'h02);
        wr(2'h2, 8'h7F);
        rst_n <= 1'b0;
        @(posedge clock);
        @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        #1;
        check("rdata idle", reg_rdata, 8'h00);
        rd(2'h0, 8'h00);
        rd(2'h1, 8'hFF);
        rd(2'h2, 8'h00);
        rd(2'h3, 8'h00);
        $display("reset done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_regs;
        t_prescale(2'h0, 8'h01);
        t_prescale(2'h1, 8'h04);
        t_prescale(2'h2, 8'h10);
        t_prescale(2'h3, 8'h10);
        t_wrap;
        t_post(4'h0);
        t_post(4'h1);
        t_post(4'hF);
        t_flag;
        t_reset;
        end_of_test;
    end
endmodule
